// >>> design/efci_capture.v
// Failing-data capture of the first uncorrectable read
`timescale 1ns/10ps
`default_nettype none
`include "efci_regs.vh"

module efci_capture #(
    parameter DATA_W  = 64,
    parameter ECC_EN  = 1
) (
    // Clock and reset
    input  wire                clk_in,
    input  wire                rst_b_in,
    // Read-side event
    input  wire                uncorr_event_in,
    input  wire [DATA_W-1:0]   rd_data_raw_in,
    input  wire                rearm_in,
    // Captured data
    output wire [DATA_W-1:0]   capture_data_out,
    output wire                armed_out
);

    reg              armed;
    reg [DATA_W-1:0] captured;

    generate
        if (ECC_EN == 1) begin : g_cap
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    armed    <= 1'b1;
                    captured <= {DATA_W{1'b0}};
                end else begin
                    if (armed && uncorr_event_in) begin
                        captured <= rd_data_raw_in;
                        armed    <= 1'b0;
                    end else if (rearm_in) begin
                        armed <= 1'b1;
                    end
                end
            end
        end else begin : g_nocap
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    armed    <= 1'b0;
                    captured <= {DATA_W{1'b0}};
                end else begin
                    armed    <= 1'b0;
                    captured <= {DATA_W{1'b0}};
                end
            end
        end
    endgenerate

    assign capture_data_out = captured;
    assign armed_out        = armed;

endmodule
`default_nettype wire

// >>> design/efci_inject.v
// Self-clearing data fault injection on the block RAM write path
`timescale 1ns/10ps
`default_nettype none
`include "efci_regs.vh"

module efci_inject #(
    parameter DATA_W   = 64,
    parameter INJ_EN   = 1,
    parameter ECC_EN   = 1
) (
    // Clock and reset
    input  wire                clk_in,
    input  wire                rst_b_in,
    // Software load of one mask word
    input  wire                load_in,
    input  wire [1:0]          load_word_in,
    input  wire [31:0]         load_data_in,
    // Write path
    input  wire                wr_en_in,
    input  wire [DATA_W-1:0]   wr_data_in,
    output wire [DATA_W-1:0]   wr_data_out
);

    localparam NWORDS = (DATA_W + 31) / 32;

    reg [DATA_W-1:0] inj_mask;
    reg [DATA_W-1:0] next_inj_mask;
    integer          i;

    // Load wins over auto-clear so a fresh mask is never lost
    always @* begin
        next_inj_mask = inj_mask;
        if (wr_en_in) begin
            next_inj_mask = {DATA_W{1'b0}};
        end
        if (load_in) begin
            for (i = 0; i < NWORDS; i = i + 1) begin
                if (load_word_in == i[1:0]) begin
                    next_inj_mask[i*32 +: 32] = load_data_in;
                end
            end
        end
    end

    generate
        if (INJ_EN == 1 && ECC_EN == 1) begin : g_inj
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    inj_mask <= {DATA_W{1'b0}};
                end else begin
                    inj_mask <= next_inj_mask;
                end
            end
            // Check bits are generated elsewhere from clean data
            assign wr_data_out = wr_data_in ^ (wr_en_in ? inj_mask : {DATA_W{1'b0}});
        end else begin : g_noinj
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    inj_mask <= {DATA_W{1'b0}};
                end else begin
                    inj_mask <= {DATA_W{1'b0}};
                end
            end
            assign wr_data_out = wr_data_in;
        end
    endgenerate

endmodule
`default_nettype wire

// >>> design/efci_regs.vh
// Register map, field positions, reset values and configuration constants for ECC diagnostics
`ifndef EFCI_REGS_VH
`define EFCI_REGS_VH

// Register byte offsets (APB, one aligned 32-bit word each)
`define EFCI_OFF_ERR_STATUS   12'h000
`define EFCI_OFF_IRQ_MASK     12'h004
`define EFCI_OFF_FAIL_W0      12'h010
`define EFCI_OFF_FAIL_W1      12'h014
`define EFCI_OFF_FAIL_W2      12'h018
`define EFCI_OFF_FAIL_W3      12'h01c
`define EFCI_OFF_INJ_W0       12'h020
`define EFCI_OFF_INJ_W1       12'h024
`define EFCI_OFF_INJ_W2       12'h028
`define EFCI_OFF_INJ_W3       12'h02c

// Status and mask fields
`define EFCI_BIT_UNCORR       0
`define EFCI_BIT_CORR         1
`define EFCI_STATUS_W         2

// Reset values
`define EFCI_RST_WORD         32'h0000_0000
`define EFCI_RST_STATUS       2'h0
`define EFCI_RST_MASK         2'h0

// Word geometry
`define EFCI_WORD_W           32
`define EFCI_MAX_WORDS        4
`define EFCI_ADDR_W           12

`endif

// >>> design/efci_top.v
// APB register block for ECC failing-data capture and data fault injection
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "efci_regs.vh"

// Summary of operation
// - First uncorrectable read stores data bits 63:32 in capture word 1.
// - Capture holds until uncorrectable flag is cleared, then re-arms.
// - Capture is armed right after reset.
// - Capture word 1 used only when data width exceeds 32.
// - Words 2 and 3 capture bits 95:64 above 64 bits and 127:96 above 96 bits.
// - Capture registers exist only when ECC is enabled.
// - Inject word 0 flips data bits 31:0 on next write; check bits untouched.
// - Injection mask self-clears once applied to a write.
// - Injection registers exist only with both injection and ECC enabled.
// - Inject word 1 flips bits 63:32 when width exceeds 32.
// - Inject words 2 and 3 flip bits 95:64 above 64 and 127:96 above 96.
// - Uncorrectable flag clears on write of one; zero leaves it.
module efci_top #(
    parameter DATA_W   = 64,
    parameter ECC_EN   = 1,
    parameter INJ_EN   = 1
) (
    // Clock and reset
    input  wire                      clk_in,
    input  wire                      rst_b_in,
    // APB slave
    input  wire                      psel_in,
    input  wire                      penable_in,
    input  wire                      pwrite_in,
    input  wire [`EFCI_ADDR_W-1:0]   paddr_in,
    input  wire [31:0]               pwdata_in,
    output wire                      pready_out,
    output reg  [31:0]               prdata_out,
    output wire                      pslverr_out,
    // Read path events from the ECC checker
    input  wire                      uncorr_event_in,
    input  wire                      corr_event_in,
    input  wire [DATA_W-1:0]         rd_data_raw_in,
    // Write path to block RAM
    input  wire                      wr_en_in,
    input  wire [DATA_W-1:0]         wr_data_in,
    output wire [DATA_W-1:0]         wr_data_out,
    // Interrupt
    output wire                      irq_out
);

    localparam NWORDS = (DATA_W + 31) / 32;

    wire                 apb_wr;
    wire                 apb_rd;
    wire                 hit;
    wire [DATA_W-1:0]    capture_data;
    wire                 capture_armed;
    wire                 flag_clr_uncorr;
    wire                 inj_load;
    wire [2:0]           inj_index;
    reg  [`EFCI_STATUS_W-1:0] err_status;
    reg  [`EFCI_STATUS_W-1:0] next_err_status;
    reg  [`EFCI_STATUS_W-1:0] irq_mask;
    reg  [31:0]          next_prdata;

    // Returns index of a data word register, or 3'h7 when not one
    function [2:0] word_index;
        input [`EFCI_ADDR_W-1:0] addr;
        input                    inject;
        begin
            word_index = 3'h7;
            if (inject) begin
                if (addr == `EFCI_OFF_INJ_W0) word_index = 3'h0;
                if (addr == `EFCI_OFF_INJ_W1) word_index = 3'h1;
                if (addr == `EFCI_OFF_INJ_W2) word_index = 3'h2;
                if (addr == `EFCI_OFF_INJ_W3) word_index = 3'h3;
            end else begin
                if (addr == `EFCI_OFF_FAIL_W0) word_index = 3'h0;
                if (addr == `EFCI_OFF_FAIL_W1) word_index = 3'h1;
                if (addr == `EFCI_OFF_FAIL_W2) word_index = 3'h2;
                if (addr == `EFCI_OFF_FAIL_W3) word_index = 3'h3;
            end
        end
    endfunction

    // Zero-wait slave: every access completes in its first access cycle
    assign pready_out = 1'b1;
    assign apb_wr     = psel_in && penable_in && pwrite_in;
    assign apb_rd     = psel_in && penable_in && !pwrite_in;

    // Words beyond the data width stay mapped: they read zero, no error
    assign hit = (paddr_in == `EFCI_OFF_ERR_STATUS) ||
                 (paddr_in == `EFCI_OFF_IRQ_MASK) ||
                 (word_index(paddr_in, 1'b0) != 3'h7) ||
                 (word_index(paddr_in, 1'b1) != 3'h7);
    assign pslverr_out = psel_in && penable_in && !hit;

    // Read of status clears it; write-one-to-clear also supported
    assign flag_clr_uncorr = (apb_wr && (paddr_in == `EFCI_OFF_ERR_STATUS) &&
                              pwdata_in[`EFCI_BIT_UNCORR]) ||
                             (apb_rd && (paddr_in == `EFCI_OFF_ERR_STATUS));

    always @* begin
        next_err_status = err_status;
        if (apb_wr && (paddr_in == `EFCI_OFF_ERR_STATUS)) begin
            next_err_status = err_status & ~pwdata_in[`EFCI_STATUS_W-1:0];
        end
        if (apb_rd && (paddr_in == `EFCI_OFF_ERR_STATUS)) begin
            next_err_status = {`EFCI_STATUS_W{1'b0}};
        end
        // Set wins over a same-cycle clear
        if (uncorr_event_in) begin
            next_err_status[`EFCI_BIT_UNCORR] = 1'b1;
        end
        if (corr_event_in) begin
            next_err_status[`EFCI_BIT_CORR] = 1'b1;
        end
    end

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_status <= `EFCI_RST_STATUS;
            irq_mask   <= `EFCI_RST_MASK;
        end else begin
            err_status <= next_err_status;
            if (apb_wr && (paddr_in == `EFCI_OFF_IRQ_MASK)) begin
                irq_mask <= pwdata_in[`EFCI_STATUS_W-1:0];
            end
        end
    end

    assign irq_out = |(err_status & irq_mask);

    // Read data mux; write-only inject words read as zero
    always @* begin
        next_prdata = `EFCI_RST_WORD;
        if (paddr_in == `EFCI_OFF_ERR_STATUS) begin
            next_prdata[`EFCI_STATUS_W-1:0] = err_status;
        end else if (paddr_in == `EFCI_OFF_IRQ_MASK) begin
            next_prdata[`EFCI_STATUS_W-1:0] = irq_mask;
        end else if (ECC_EN == 1 && word_index(paddr_in, 1'b0) < NWORDS) begin
            // Upper words exist only for wide data
            case (word_index(paddr_in, 1'b0))
                3'h0:    next_prdata = capture_data[31:0];
                3'h1:    next_prdata = capture_data[32*(NWORDS > 1 ? 1 : 0) +: 32];
                3'h2:    next_prdata = capture_data[32*(NWORDS > 2 ? 2 : 0) +: 32];
                3'h3:    next_prdata = capture_data[32*(NWORDS > 3 ? 3 : 0) +: 32];
                default: next_prdata = `EFCI_RST_WORD;
            endcase
        end
    end

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out <= `EFCI_RST_WORD;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= next_prdata;
        end
    end

    assign inj_index = word_index(paddr_in, 1'b1);
    assign inj_load  = apb_wr && (inj_index < NWORDS);

    efci_capture #(
        .DATA_W           (DATA_W),
        .ECC_EN           (ECC_EN)
    ) u_capture (
        .clk_in           (clk_in),
        .rst_b_in         (rst_b_in),
        .uncorr_event_in  (uncorr_event_in),
        .rd_data_raw_in   (rd_data_raw_in),
        .rearm_in         (flag_clr_uncorr),
        .capture_data_out (capture_data),
        .armed_out        (capture_armed)
    );

    efci_inject #(
        .DATA_W           (DATA_W),
        .INJ_EN           (INJ_EN),
        .ECC_EN           (ECC_EN)
    ) u_inject (
        .clk_in           (clk_in),
        .rst_b_in         (rst_b_in),
        .load_in          (inj_load),
        .load_word_in     (inj_index[1:0]),
        .load_data_in     (pwdata_in),
        .wr_en_in         (wr_en_in),
        .wr_data_in       (wr_data_in),
        .wr_data_out      (wr_data_out)
    );

endmodule
`default_nettype wire

// >>> verif/efci_bram_model.sv
// Block RAM data port model: issues writes and faulty reads
`timescale 1ns/10ps
`default_nettype none
module efci_bram_model (
    input  wire logic        clk_in,
    input  wire logic [63:0] ram_in,
    output logic             wr_en_out,
    output logic [63:0]      wr_data_out,
    output logic             uncorr_out,
    output logic             corr_out,
    output logic [63:0]      rd_data_out
);
    logic [63:0] stored;
    initial begin
        wr_en_out = 1'b0;
        wr_data_out = 64'h0;
        uncorr_out = 1'b0;
        corr_out = 1'b0;
        rd_data_out = 64'h0;
    end
    always @(posedge clk_in) if (wr_en_out) stored <= ram_in;
    // Released data lines show the inverse, never the last value
    task automatic put(input logic [63:0] d);
        wr_en_out <= 1'b1;
        wr_data_out <= d;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
        @(posedge clk_in);
    endtask
    task automatic get_err(input logic [63:0] d, input logic ue);
        uncorr_out <= ue;
        corr_out <= !ue;
        rd_data_out <= d;
        @(posedge clk_in);
        uncorr_out <= 1'b0;
        corr_out <= 1'b0;
        rd_data_out <= ~d;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// >>> verif/efci_chk.sv
// Checker for ECC capture and fault injection registers
`timescale 1ns/10ps
`default_nettype none
`include "efci_regs.vh"
module efci_chk #(
    parameter DATA_W = 64
) (
    input wire logic              clk_in,
    input wire logic              rst_b_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [11:0]       paddr_in,
    input wire logic [31:0]       pwdata_in,
    input wire logic              pready_out,
    input wire logic [31:0]       prdata_out,
    input wire logic              pslverr_out,
    input wire logic              uncorr_event_in,
    input wire logic              corr_event_in,
    input wire logic [DATA_W-1:0] rd_data_raw_in,
    input wire logic              wr_en_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic [DATA_W-1:0] wr_data_out,
    input wire logic              irq_out
);
    logic [31:0]       m0, m1, cw0, cw1;
    logic [DATA_W-1:0] cap;
    logic              arm, acc, wr, rd, ok;
    logic [1:0]        st, mk, clr;
    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in;
    assign rd = acc && !pwrite_in;
    assign ok = paddr_in inside {12'h000, 12'h004, [12'h010:12'h02c]} && paddr_in[1:0] == 2'h0;
    assign clr = (acc && paddr_in == `EFCI_OFF_ERR_STATUS) ? (pwrite_in ? pwdata_in[1:0] : 2'h3) : 2'h0;
    assign cw0 = cap[31:0];
    assign cw1 = cap[63:32];
    // Shadow state; a read clears status, so reads see the setup-cycle value
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            m0 <= '0;
            m1 <= '0;
            cap <= '0;
            arm <= 1'b1;
            st <= '0;
            mk <= '0;
        end else begin
            st <= (st & ~clr) | {corr_event_in, uncorr_event_in};
            if (uncorr_event_in && arm) cap <= rd_data_raw_in;
            arm <= arm ? !uncorr_event_in : clr[0];
            if (wr && paddr_in == `EFCI_OFF_IRQ_MASK) mk <= pwdata_in[1:0];
            m0 <= (wr && paddr_in == `EFCI_OFF_INJ_W0) ? pwdata_in : (wr_en_in ? '0 : m0);
            m1 <= (wr && paddr_in == `EFCI_OFF_INJ_W1) ? pwdata_in : (wr_en_in ? '0 : m1);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    chk_ready_always: assert property (pready_out) else $error("pready low");
    chk_inject_low: assert property (
        wr_en_in |-> (wr_data_out[31:0] ^ wr_data_in[31:0]) == m0) else $error("word 0 flip");
    chk_inject_high: assert property (
        wr_en_in |-> (wr_data_out[63:32] ^ wr_data_in[63:32]) == m1) else $error("word 1 flip");
    chk_idle_pass: assert property (
        !wr_en_in |-> wr_data_out == wr_data_in) else $error("idle data altered");
    chk_mask_clear: assert property (
        $past(wr_en_in) && !$past(wr) |-> wr_data_out == wr_data_in) else $error("mask kept");
    chk_cap_word0: assert property (
        rd && paddr_in == `EFCI_OFF_FAIL_W0 |-> prdata_out == $past(cw0)) else $error("cap word 0");
    chk_cap_word1: assert property (
        rd && paddr_in == `EFCI_OFF_FAIL_W1 |-> prdata_out == $past(cw1)) else $error("cap word 1");
    chk_cap_upper: assert property (
        rd && paddr_in[11:3] == 9'h003 |-> prdata_out == 32'h0) else $error("upper word");
    chk_status_read: assert property (
        rd && paddr_in == 12'h000 |-> prdata_out == {30'h0, $past(st)}) else $error("status");
    chk_irq_level: assert property (irq_out == |(st & mk)) else $error("irq level");
    chk_unmapped_err: assert property (acc |-> pslverr_out == !ok) else $error("pslverr");
    chk_inject_reads: assert property (
        rd && paddr_in[11:4] == 8'h02 |-> prdata_out == 32'h0) else $error("inject read");
    cover property (uncorr_event_in && arm);
    cover property (wr_en_in && m0 != 32'h0);
    cover property (irq_out);
endmodule
bind efci_top efci_chk #(.DATA_W(DATA_W)) u_efci_chk (
    .clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pready_out, .prdata_out, .pslverr_out, .uncorr_event_in, .corr_event_in,
    .rd_data_raw_in, .wr_en_in, .wr_data_in, .wr_data_out, .irq_out
);
`default_nettype wire

// >>> verif/efci_tb.sv
// Testbench for ECC capture and fault injection registers
`timescale 1ns/10ps
`default_nettype none
`include "efci_regs.vh"
module testbench;
    localparam logic [63:0] DA = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] DB = 64'hfedc_ba98_7654_3210;
    logic        clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr, irq;
    logic        wr_en, ue, ce, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [63:0] wd, ram, raw;
    int          n_mismatch = 0;
    int          check_count = 0;
    efci_top u_efci_top (
        .clk_in, .rst_b_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
        .pslverr_out(pslverr), .uncorr_event_in(ue), .corr_event_in(ce),
        .rd_data_raw_in(raw), .wr_en_in(wr_en), .wr_data_in(wd), .wr_data_out(ram),
        .irq_out(irq)
    );
    efci_bram_model u_efci_bram_model (
        .clk_in, .ram_in(ram), .wr_en_out(wr_en), .wr_data_out(wd), .uncorr_out(ue),
        .corr_out(ce), .rd_data_out(raw)
    );
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Idle cycle after each transfer keeps drivers to one assignment per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic err);
        apb(1'b0, a, 32'h0);
        check("prdata", {32'h0, x}, {32'h0, q});
        check("pslverr", {63'h0, err}, {63'h0, e});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        #500000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        rst_b_in = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 13; i++) rd_chk(12'(i * 4), 32'h0, i == 2 || i == 3 || i == 12);
        apb(1'b1, 12'h100, 32'h5);
        check("pslverr", 64'h1, {63'h0, e});
        apb(1'b1, `EFCI_OFF_IRQ_MASK, 32'h1);
        u_efci_bram_model.put(DA);
        check("ram", DA, u_efci_bram_model.stored);
        apb(1'b1, `EFCI_OFF_INJ_W0, 32'h10);
        u_efci_bram_model.put(DA);
        check("ram", DA ^ 64'h10, u_efci_bram_model.stored);
        u_efci_bram_model.put(DB);
        check("ram", DB, u_efci_bram_model.stored);
        apb(1'b1, `EFCI_OFF_INJ_W1, 32'h8000_0000);
        u_efci_bram_model.put(DA);
        check("ram", DA ^ {1'b1, 63'h0}, u_efci_bram_model.stored);
        apb(1'b1, `EFCI_OFF_INJ_W2, 32'h1);
        u_efci_bram_model.put(DB);
        check("ram", DB, u_efci_bram_model.stored);
        u_efci_bram_model.get_err(DA, 1'b1);
        check("irq", 64'h1, {63'h0, irq});
        rd_chk(`EFCI_OFF_FAIL_W0, DA[31:0], 1'b0);
        rd_chk(`EFCI_OFF_FAIL_W1, DA[63:32], 1'b0);
        u_efci_bram_model.get_err(DB, 1'b1);
        rd_chk(`EFCI_OFF_FAIL_W1, DA[63:32], 1'b0);
        rd_chk(`EFCI_OFF_FAIL_W2, 32'h0, 1'b0);
        rd_chk(`EFCI_OFF_FAIL_W3, 32'h0, 1'b0);
        apb(1'b1, `EFCI_OFF_ERR_STATUS, 32'h0);
        check("irq", 64'h1, {63'h0, irq});
        apb(1'b1, `EFCI_OFF_ERR_STATUS, 32'h1);
        check("irq", 64'h0, {63'h0, irq});
        u_efci_bram_model.get_err(DB, 1'b1);
        rd_chk(`EFCI_OFF_FAIL_W1, DB[63:32], 1'b0);
        rd_chk(`EFCI_OFF_ERR_STATUS, 32'h1, 1'b0);
        rd_chk(`EFCI_OFF_ERR_STATUS, 32'h0, 1'b0);
        u_efci_bram_model.get_err(DA, 1'b0);
        check("irq", 64'h0, {63'h0, irq});
        apb(1'b1, `EFCI_OFF_IRQ_MASK, 32'h3);
        check("irq", 64'h1, {63'h0, irq});
        apb(1'b1, `EFCI_OFF_ERR_STATUS, 32'h2);
        check("irq", 64'h0, {63'h0, irq});
        give_verdict();
    end
endmodule
`default_nettype wire
